// ===== common/mode_defaults_pkg.sv
package mode_defaults_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Operating modes as committed by the mode state machine
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_STANDBY  = 3'h1,
    MODE_NORMAL   = 3'h3,
    MODE_SLEEP    = 3'h2,
    MODE_OVERTEMP = 3'h6,
    MODE_RESET    = 3'h7
  } op_mode_t;

  // Internal phase after power-on
  typedef enum logic [1:0] {
    PH_INIT = 2'h0,
    PH_OFF  = 2'h1,
    PH_RUN  = 2'h3
  } phase_t;

  // Mode control codes
  localparam logic [2:0] MC_POWER_ON = 3'h4;
  localparam logic [2:0] MC_STANDBY  = 3'h4;
  localparam logic [2:0] MC_NORMAL   = 3'h7;
  localparam logic [2:0] MC_SLEEP    = 3'h1;
  localparam logic [2:0] MC_RESET    = 3'h4;

  // Field load values
  localparam logic [3:0] NWP_DEFAULT   = 4'h4;
  localparam logic [1:0] RCC_CLEARED   = 2'h0;
  localparam logic [1:0] RCC_ONE       = 2'h1;
  localparam logic [1:0] RCC_LIMP      = 2'h3;
  localparam logic [4:0] RSS_POWER_ON  = 5'h00;
  localparam logic [4:0] RSS_OVERTEMP  = 5'h12;
  localparam logic [2:0] WMC_SW_DEV    = 3'h1;
  localparam logic [2:0] WMC_DEFAULT   = 3'h2;
  localparam logic [1:0] MAIN_REG_THRESHOLD_FIXED   = 2'h0;

  // Non-volatile configuration, presented continuously
  typedef struct packed {
    logic [1:0] restart_limit_cfg;
    logic       sw_dev_mode_cfg;
    logic       sleep_allow_cfg;
    logic       forced_normal_cfg;
    logic [1:0] main_reg_threshold_startup;
    logic [1:0] aux_supply_startup_cfg;
  } nv_cfg_t;

  // Live hardware state, arriving from outside the clock domain
  typedef struct packed {
    logic       overtemp_warn_status;
    logic       sw_dev_mode_status;
    logic       main_reg_status;
    logic       supply_voltage_status;
    logic       watchdog_status;
    logic [1:0] aux_supply_status;
    logic       can_tx_status;
    logic       nonvolatile_programmed_status;
    logic       nv_write_counter_status;
  } live_status_t;

  // Fields that software reads and writes
  typedef struct packed {
    logic [2:0] operating_mode_select;
    logic [3:0] watchdog_period_sel;
    logic [2:0] watchdog_mode_sel;
    logic       limp_home_ctrl;
    logic [1:0] main_reg_threshold;
    logic [1:0] supply_ctrl;
    logic       system_event_enable;
    logic       overtemp_warn_enable;
    logic       spi_failure_enable;
    logic       wake_fall_enable;
    logic       wake_rise_enable;
    logic       pn_data_mask_enable;
    logic       pn_config_valid;
  } ctrl_fields_t;

  // Fields that software only reads, except power_on_flag, which sw_po_clear clears
  typedef struct packed {
    logic         normal_entered_flag;
    logic [1:0]   reset_event_counter;
    logic [4:0]   reset_cause_code;
    logic         power_on_flag;
    nv_cfg_t      nv_cfg;
    live_status_t live;
  } status_fields_t;

  localparam ctrl_fields_t CTRL_POWER_ON = '{
    operating_mode_select: MC_POWER_ON,
    watchdog_period_sel:   NWP_DEFAULT,
    watchdog_mode_sel:     WMC_DEFAULT,
    limp_home_ctrl:        1'b0,
    main_reg_threshold:    MAIN_REG_THRESHOLD_FIXED,
    supply_ctrl:           2'h0,
    system_event_enable:   1'b1,
    overtemp_warn_enable:  1'b0,
    spi_failure_enable:    1'b0,
    wake_fall_enable:      1'b0,
    wake_rise_enable:      1'b0,
    pn_data_mask_enable:   1'b1,
    pn_config_valid:       1'b0
  };

endpackage

// ===== logic/status_sync.sv
module status_sync
  import mode_defaults_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Levels from outside the domain
  input  wire logic [W-1:0] async_in,
  // Filtered levels
  output logic      [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, out_reg;
      logic out_next;

      // A change counts only once the two later stages agree
      always_comb begin
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg  <= async_in[i];
          s2_reg  <= s1_reg;
          s3_reg  <= s2_reg;
          out_reg <= out_next;
        end
      end

      assign sync_out[i] = out_reg;
    end
  endgenerate

endmodule

// ===== logic/limp_delay_timer.sv
module limp_delay_timer
  import mode_defaults_pkg::*;
#(
  parameter int CYCLES = 1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Control
  input  wire logic restart,
  input  wire logic run,
  // Result
  output logic      expired
);

  localparam int CW = $clog2(CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  logic [CW-1:0] count_reg, count_next;
  logic          expired_reg, expired_next;

  // Saturates so a long stay cannot wrap back below the delay
  always_comb begin
    count_next   = count_reg;
    expired_next = expired_reg;
    if (restart) begin
      count_next   = '0;
      expired_next = 1'b0;
    end else if (run) begin
      if (count_reg > LIMIT) begin
        expired_next = 1'b1;
      end else begin
        count_next = count_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_reg   <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg   <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule

// ===== logic/mode_register_defaults.sv
module mode_register_defaults
  import mode_defaults_pkg::*;
#(
  parameter bit       V1_IS_5V      = 1'b1,
  parameter bit       HAS_PN        = 1'b1,
  parameter int       LIMP_DELAY_NS = 100000,
  parameter bit [2:0] FNM_WDOG_MODE = 3'h1
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rstn,
  // Mode state machine
  input  wire logic           mode_enter,
  input  wire op_mode_t       mode_new,
  input  wire logic [4:0]     reset_source,
  // Host access
  input  wire logic           spi_active,
  input  wire logic           sw_wr,
  input  wire ctrl_fields_t   sw_wdata,
  input  wire logic           sw_po_clear,
  // Non-volatile memory and hardware state
  input  wire nv_cfg_t        nv_cfg,
  input  wire live_status_t   live_async,
  // Register contents
  output ctrl_fields_t        ctrl_out,
  output status_fields_t      status_out,
  output op_mode_t            mode_out,
  output logic                spi_discard
);

  localparam int LIMP_CYCLES_RAW = (LIMP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LIMP_CYCLES     = (LIMP_CYCLES_RAW < 1) ? 1 : LIMP_CYCLES_RAW;
  localparam int LIVE_W          = $bits(live_status_t);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised hardware state and limp delay

  live_status_t   live;
  logic           limp_expired;
  logic           in_limp_mode;

  // Field state, declared here because the limp timer control reads the mode
  phase_t         phase_reg, phase_next;
  op_mode_t       mode_reg, mode_next;
  ctrl_fields_t   ctrl_reg, ctrl_next;
  status_fields_t stat_reg, stat_next;
  logic           discard_reg, discard_next;

  status_sync #(
    .W (LIVE_W)
  ) u_status_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in (live_async),
    .sync_out (live)
  );

  assign in_limp_mode = (mode_reg == MODE_OVERTEMP) || (mode_reg == MODE_RESET);

  limp_delay_timer #(
    .CYCLES (LIMP_CYCLES)
  ) u_limp_delay_timer (
    .mclk    (mclk),
    .rstn    (rstn),
    .restart (mode_enter),
    .run     (in_limp_mode),
    .expired (limp_expired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Field state

  always_comb begin
    phase_next   = phase_reg;
    mode_next    = mode_reg;
    ctrl_next    = ctrl_reg;
    stat_next    = stat_reg;
    discard_next = 1'b0;

    unique case (phase_reg)
      // Power-on values that depend on straps are caught one cycle after release
      PH_INIT: begin
        ctrl_next.main_reg_threshold = V1_IS_5V ? nv_cfg.main_reg_threshold_startup : MAIN_REG_THRESHOLD_FIXED;
        ctrl_next.supply_ctrl = nv_cfg.aux_supply_startup_cfg;
        ctrl_next.watchdog_mode_sel = nv_cfg.sw_dev_mode_cfg ? WMC_SW_DEV : WMC_DEFAULT;
        phase_next = PH_OFF;
      end
      PH_OFF: begin
        if (mode_enter) begin
          phase_next = PH_RUN;
        end
      end
      PH_RUN: begin
        phase_next = PH_RUN;
      end
    endcase

    // host write loses to mode update
    if (sw_wr && !mode_enter && (phase_reg != PH_INIT)) begin
      ctrl_next = sw_wdata;
      if (!HAS_PN) begin
        ctrl_next.pn_data_mask_enable = 1'b0;
        ctrl_next.pn_config_valid     = 1'b0;
      end
      if (!V1_IS_5V) begin
        ctrl_next.main_reg_threshold = MAIN_REG_THRESHOLD_FIXED;
      end
    end

    if (sw_po_clear) begin
      stat_next.power_on_flag = 1'b0;
    end

    // updates land in the commit cycle
    if (mode_enter) begin
      mode_next = mode_new;
      discard_next = spi_active;
      // fields not named below keep their value
      unique case (mode_new)
        MODE_STANDBY: begin
          ctrl_next.operating_mode_select = MC_STANDBY;
        end
        MODE_NORMAL: begin
          ctrl_next.operating_mode_select = MC_NORMAL;
          if (nv_cfg.forced_normal_cfg) begin
            ctrl_next.watchdog_mode_sel = FNM_WDOG_MODE;
          end else begin
            stat_next.normal_entered_flag = 1'b0;
          end
        end
        MODE_SLEEP: begin
          ctrl_next.operating_mode_select = MC_SLEEP;
        end
        MODE_OVERTEMP: begin
          ctrl_next.watchdog_period_sel = NWP_DEFAULT;
          stat_next.reset_cause_code = RSS_OVERTEMP;
        end
        MODE_RESET: begin
          ctrl_next.operating_mode_select = MC_RESET;
          ctrl_next.watchdog_period_sel = NWP_DEFAULT;
          stat_next.reset_event_counter = stat_reg.reset_event_counter + RCC_ONE;
          stat_next.reset_cause_code = reset_source;
          ctrl_next.watchdog_mode_sel = nv_cfg.sw_dev_mode_cfg ? WMC_SW_DEV : WMC_DEFAULT;
        end
        default: begin
          ctrl_next.operating_mode_select = MC_POWER_ON;
        end
      endcase
    end

    if ((mode_reg == MODE_OVERTEMP) && limp_expired && !mode_enter) begin
      ctrl_next.limp_home_ctrl = 1'b1;
    end
    // reset limp on count or delay
    if ((mode_reg == MODE_RESET) && !mode_enter &&
        ((stat_reg.reset_event_counter == RCC_LIMP) || limp_expired)) begin
      ctrl_next.limp_home_ctrl = 1'b1;
    end

    stat_next.nv_cfg = nv_cfg;

    // zero until first mode entry, live afterwards; can_tx_status only in MODE_NORMAL, two nonvolatile bits always live
    if (phase_next == PH_RUN) begin
      stat_next.live = live;
    end else begin
      stat_next.live = '0;
    end
    stat_next.live.can_tx_status = (phase_next == PH_RUN) && (mode_next == MODE_NORMAL) &&
                                   live.can_tx_status;
    stat_next.live.nonvolatile_programmed_status = live.nonvolatile_programmed_status;
    stat_next.live.nv_write_counter_status       = live.nv_write_counter_status;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_reg   <= PH_INIT;
      mode_reg    <= MODE_OFF;
      ctrl_reg    <= CTRL_POWER_ON;
      if (!HAS_PN) begin
        ctrl_reg.pn_data_mask_enable <= 1'b0;
      end
      stat_reg.normal_entered_flag <= 1'b1;
      stat_reg.reset_event_counter <= RCC_CLEARED;
      stat_reg.reset_cause_code    <= RSS_POWER_ON;
      stat_reg.power_on_flag       <= 1'b1;
      stat_reg.nv_cfg              <= '0;
      stat_reg.live                <= '0;
      discard_reg <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      mode_reg    <= mode_next;
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      discard_reg <= discard_next;
    end
  end

  assign ctrl_out    = ctrl_reg;
  assign status_out  = stat_reg;
  assign mode_out    = mode_reg;
  assign spi_discard = discard_reg;

endmodule

// ===== sim/mode_register_defaults_chk.sv
module mode_register_defaults_chk
  import mode_defaults_pkg::*;
(
  // Clock and reset
  input wire logic           mclk,
  input wire logic           rstn,
  // Causes
  input wire logic           mode_enter,
  input wire op_mode_t       mode_new,
  input wire logic           spi_active,
  input wire nv_cfg_t        nv_cfg,
  // Register contents
  input wire ctrl_fields_t   ctrl_out,
  input wire status_fields_t status_out,
  input wire op_mode_t       mode_out,
  input wire logic           spi_discard
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  mc_normal_a: assert property (
    mode_enter && mode_new == MODE_NORMAL |=> ctrl_out.operating_mode_select == 3'h7)
    else $error("mode select not 111 after normal entry");
  nms_clear_a: assert property (
    mode_enter && mode_new == MODE_NORMAL && !nv_cfg.forced_normal_cfg |=> !status_out.normal_entered_flag)
    else $error("normal flag not cleared");
  nwp_load_a: assert property (
    mode_enter && mode_new inside {MODE_OVERTEMP, MODE_RESET} |=> ctrl_out.watchdog_period_sel == 4'h4)
    else $error("watchdog period not reloaded");
  rcc_inc_a: assert property (
    mode_enter && mode_new == MODE_RESET
    |=> status_out.reset_event_counter == $past(status_out.reset_event_counter) + 2'h1)
    else $error("reset counter not incremented");
  rss_ot_a: assert property (
    mode_enter && mode_new == MODE_OVERTEMP |=> status_out.reset_cause_code == 5'h12)
    else $error("overtemp cause code wrong");
  limp_cnt_a: assert property (
    mode_enter && mode_new == MODE_RESET && status_out.reset_event_counter == 2'h2 |-> ##2 ctrl_out.limp_home_ctrl)
    else $error("limp not set on third reset");
  wmc_reset_a: assert property (
    mode_enter && mode_new == MODE_RESET
    |=> ctrl_out.watchdog_mode_sel == ($past(nv_cfg.sw_dev_mode_cfg) ? 3'h1 : 3'h2))
    else $error("watchdog mode wrong after reset entry");
  discard_a: assert property (
    mode_enter |=> spi_discard == $past(spi_active))
    else $error("discard pulse does not match frame");
  cts_zero_a: assert property (
    mode_out != MODE_NORMAL && $past(mode_out) != MODE_NORMAL |-> !status_out.live.can_tx_status)
    else $error("transmitter status set outside normal");
  nv_mirror_a: assert property (
    1'b1 |=> status_out.nv_cfg == $past(nv_cfg))
    else $error("configuration mirror stale");

  cover property (mode_enter && mode_new == MODE_RESET && status_out.reset_event_counter == 2'h2);
  cover property (spi_discard);
  cover property ($rose(ctrl_out.limp_home_ctrl) && mode_out == MODE_OVERTEMP);
endmodule

bind mode_register_defaults mode_register_defaults_chk mode_register_defaults_chk_inst (
  .mclk(mclk), .rstn(rstn), .mode_enter(mode_enter), .mode_new(mode_new), .spi_active(spi_active),
  .nv_cfg(nv_cfg), .ctrl_out(ctrl_out), .status_out(status_out), .mode_out(mode_out), .spi_discard(spi_discard));

// ===== sim/host_model.sv
module host_model
  import mode_defaults_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Bench request
  input  wire logic         req,
  input  wire ctrl_fields_t req_data,
  // Toward the block
  output logic              spi_active,
  output logic              sw_wr,
  output ctrl_fields_t      sw_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed;

  // Frame opens a cycle before the strobe, so a mode commit can land inside it
  // Data toggles outside the strobe, so a stale word never passes for a write
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
      spi_active <= 1'b0;
      sw_wr <= 1'b0;
      sw_wdata <= '0;
    end else begin
      sw_wr <= armed;
      sw_wdata <= armed ? req_data : ~sw_wdata;
      spi_active <= req | armed;
      armed <= req;
    end
  end
endmodule

// ===== sim/testbench.sv
module testbench
  import mode_defaults_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam nv_cfg_t      NV0 = '{2'h1, 1'b1, 1'b1, 1'b0, 2'h2, 2'h3};
  localparam ctrl_fields_t W1  = '{3'h4, 4'h9, 3'h4, 1'b0, 2'h1, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic           mclk, rstn, mode_enter, sw_po_clear, req, sw_wr, spi_active, spi_discard;
  op_mode_t       mode_new, mode_out;
  logic [4:0]     reset_source;
  nv_cfg_t        nv_cfg;
  live_status_t   live_async;
  ctrl_fields_t   sw_wdata, req_data, ctrl_out;
  status_fields_t status_out;
  int             n_errors, cmp_count;

  mode_register_defaults #(.LIMP_DELAY_NS(50)) mode_register_defaults_inst (
    .mclk(mclk), .rstn(rstn), .mode_enter(mode_enter), .mode_new(mode_new), .reset_source(reset_source),
    .spi_active(spi_active), .sw_wr(sw_wr), .sw_wdata(sw_wdata), .sw_po_clear(sw_po_clear), .nv_cfg(nv_cfg),
    .live_async(live_async), .ctrl_out(ctrl_out), .status_out(status_out), .mode_out(mode_out),
    .spi_discard(spi_discard));
  host_model host_model_inst (
    .mclk(mclk), .rstn(rstn), .req(req), .req_data(req_data), .spi_active(spi_active), .sw_wr(sw_wr),
    .sw_wdata(sw_wdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic enter(input op_mode_t m, input logic [4:0] src);
    @(posedge mclk);
    mode_enter <= 1'b1;
    mode_new <= m;
    reset_source <= src;
    @(posedge mclk);
    mode_enter <= 1'b0;
    #1;
  endtask

  // Host frame: strobe reaches the block three edges after the request
  task automatic host_write(input ctrl_fields_t d);
    @(posedge mclk);
    req_data <= d;
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("ctrl after write", d, ctrl_out);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on();
    chk("ctrl power-on", ctrl_fields_t'{3'h4, 4'h4, 3'h1, 1'b0, 2'h2, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0}, ctrl_out);
    chk("status power-on", {1'b1, 2'h0, 5'h00, 1'b1, NV0, 10'h003}, status_out);
  endtask

  task automatic t_modes();
    op_mode_t   m[3]  = '{MODE_STANDBY, MODE_NORMAL, MODE_SLEEP};
    logic [2:0] mc[3] = '{3'h4, 3'h7, 3'h1};
    for (int i = 0; i < 3; i++) begin
      enter(m[i], 5'h00);
      chk("mode select", mc[i], ctrl_out.operating_mode_select);
      chk("mode held", m[i], mode_out);
      repeat (2) @(posedge mclk);
      #1;
      chk("live status", (m[i] == MODE_NORMAL) ? 10'h3FF : 10'h3FB, status_out.live);
    end
    chk("normal flag", 1'b0, status_out.normal_entered_flag);
  endtask

  task automatic t_keep();
    host_write(W1);
    enter(MODE_STANDBY, 5'h00);
    chk("ctrl kept", W1, ctrl_out);
  endtask

  task automatic t_reset();
    for (int i = 1; i <= 3; i++) begin
      enter(MODE_RESET, 5'h05 + 5'(i));
      chk("period", 4'h4, ctrl_out.watchdog_period_sel);
      chk("counter", i, status_out.reset_event_counter);
      chk("cause", 5'h05 + 5'(i), status_out.reset_cause_code);
      chk("wdog mode", 3'h1, ctrl_out.watchdog_mode_sel);
      chk("limp early", 1'b0, ctrl_out.limp_home_ctrl);
    end
    @(posedge mclk);
    #1;
    chk("limp on count", 1'b1, ctrl_out.limp_home_ctrl);
  endtask

  task automatic t_overtemp();
    int n;
    enter(MODE_STANDBY, 5'h00);
    host_write(W1);
    enter(MODE_OVERTEMP, 5'h00);
    chk("period", 4'h4, ctrl_out.watchdog_period_sel);
    chk("cause", 5'h12, status_out.reset_cause_code);
    chk("limp early", 1'b0, ctrl_out.limp_home_ctrl);
    for (n = 0; n < 20 && ctrl_out.limp_home_ctrl !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (ctrl_out.limp_home_ctrl !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED limp delay expected 1 seen %b", ctrl_out.limp_home_ctrl);
      wrap_up();
    end
    chk("limp delay floor", 1'b1, n >= 4);
  endtask

  // Mode commit lands on the host strobe edge
  task automatic t_discard();
    @(posedge mclk);
    req_data <= W1;
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    mode_enter <= 1'b1;
    mode_new <= MODE_SLEEP;
    @(posedge mclk);
    mode_enter <= 1'b0;
    #1;
    chk("discard", 1'b1, spi_discard);
    chk("write dropped", 4'h4, ctrl_out.watchdog_period_sel);
    chk("sleep select", 3'h1, ctrl_out.operating_mode_select);
    @(posedge mclk);
    #1;
    chk("discard pulse", 1'b0, spi_discard);
  endtask

  task automatic t_forced();
    host_write(W1);
    @(posedge mclk);
    nv_cfg.forced_normal_cfg <= 1'b1;
    enter(MODE_NORMAL, 5'h00);
    chk("forced wdog", 3'h1, ctrl_out.watchdog_mode_sel);
    chk("forced select", 3'h7, ctrl_out.operating_mode_select);
    chk("nv forced", 1'b1, status_out.nv_cfg.forced_normal_cfg);
  endtask

  task automatic t_po_clear();
    chk("po kept", 1'b1, status_out.power_on_flag);
    @(posedge mclk);
    sw_po_clear <= 1'b1;
    @(posedge mclk);
    sw_po_clear <= 1'b0;
    #1;
    chk("po cleared", 1'b0, status_out.power_on_flag);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rstn = 1'b0;
    mode_enter = 1'b0;
    mode_new = MODE_OFF;
    reset_source = 5'h00;
    sw_po_clear = 1'b0;
    req = 1'b0;
    req_data = '0;
    nv_cfg = NV0;
    live_async = '1;
    n_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    t_power_on();
    t_modes();
    t_keep();
    t_reset();
    t_overtemp();
    t_discard();
    t_forced();
    t_po_clear();
    wrap_up();
  end
endmodule
